// *** inc/ecu_opstate_pkg.sv ***
// Purpose: Shared constants for the ECU operation state controller
// Assumes: 25 MHz hclk, 32-bit AHB-Lite register bus, word access only
// Notes:   Byte offsets, field positions, reset values and timing
//          figures live here only

// ==============================================================
// Package
package ecu_opstate_pkg;

  // Clock and time base
  localparam int CLK_HZ = 25_000_000;
  localparam int US_HZ = 1_000_000;
  localparam int US_CYC = CLK_HZ / US_HZ;
  // Timer spans in microseconds (plain defaults)
  localparam int RAMP_TIME_US = 2000;
  localparam int PD_TIME_US = 2000;
  localparam int TMR_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;

  // Field positions
  localparam int CFG_AE_BIT = 0;
  localparam int CFG_AR_BIT = 1;
  localparam int STAT_MR_BIT = 8;
  localparam int STAT_RELAY_BIT = 9;
  localparam int CMD_WAKE_CLEAR_SELECT_BIT = 0;
  localparam int EV_STATE = 0;
  localparam int EV_RAMPFAIL = 1;
  localparam int EV_PWRDN = 2;
  localparam int EV_ARRESET = 3;
  localparam int EV_W = 4;

  // Reset values
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic MR_RST = 1'b0;
  localparam logic WAKE_CLEAR_SELECT_RST = 1'b0;
  localparam logic [EV_W-1:0] IRQ_MSK_RST = 4'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Operation states, one-hot
  typedef enum logic [6:0] {
    ST_SLEEP = 7'h01,
    ST_RAMP = 7'h02,
    ST_NORMAL = 7'h04,
    ST_AFTERRUN = 7'h08,
    ST_ARRESET = 7'h10,
    ST_PWRDN = 7'h20,
    ST_WAKE_CLEAR_SELECT = 7'h40
  } op_state_e;

endpackage : ecu_opstate_pkg

// *** logic/ecu_opstate_ctrl.sv ***
// Purpose: ECU supply ramp-up/shut-down operation state controller
// Assumes: Key, wake and supply comparators arrive as async pins;
//          watchdog overflow flags come from logic on hclk
// Notes:   AHB-Lite slave, one wait state per transfer
//
// What this block does
// R1: Seven operation states cover full sequence
// R2: Sleep keeps main relay off, ECU unsupplied
// R3: Standby rail and wake circuits live in sleep
// R4: Ramp state while wake high, rails undervoltage
// R5: Wake start must finish before ramp timeout
// R6: Normal drives relay from battery or status bit
// R7: Afterrun keeps whole ECU supplied
// R8: Afterrun reset bit forces reset before normal
// R9: Power-down cuts rails, holds relay, blocks outputs
// R10: Power-down stays supplied until main rail zero
// R11: Wake clear runs command per select bit
// R12: Wake clear resets lingering wake signals
// R13: Ramp to wake clear on timeout, key low
// R14: Normal to afterrun when key low, enabled
// R15: Key back without reset bit re-enters normal
// R16: Afterrun reset leaves for normal next edge
// R17: Reset clears state; wakes then pick ramp
// R18: One unique state code, reported in status
`timescale 1ns/1ps

// ==============================================================
// Top level
module ecu_opstate_ctrl
  import ecu_opstate_pkg::*;
#(
  parameter int RAMP_US = RAMP_TIME_US,
  parameter int PD_US = PD_TIME_US
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Wake and supply pins
  input wire logic key_pin,
  input wire logic wake_pin_input,
  input wire logic can_wake,
  input wire logic eot_wake,
  input wire logic main_5v_ok,
  input wire logic main_5v_zero,
  input wire logic battery_ok,
  input wire logic standby_battery_pin,
  // Watchdog events on hclk
  input wire logic powerdown_counter_overflow,
  input wire logic secure_shutoff_timer_expired,
  // Supply and relay controls
  output logic main_relay_on,
  output logic main_5v_en,
  output logic sensor_rail_en,
  output logic standby_5v_en,
  output logic wake_circuit_en,
  output logic internal_supply_en,
  output logic ext_func_en,
  output logic monitor_reset_output_n,
  // Wake clear and status
  output logic wake_clear,
  output logic wake_clear_mode,
  output logic [6:0] state_code,
  output logic irq
);

  // ============================================================
  // Input conditioning
  logic [7:0] pins_s;
  logic key_s, wake_s, v5v_ok_s, v5v_zero_s, batt_s, stby_s;
  logic ramp_ovf, pd_ovf, shut;

  pin_sync #(.W(8)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({standby_battery_pin, battery_ok, main_5v_zero,
      main_5v_ok, eot_wake, can_wake, wake_pin_input, key_pin}),
    .pin_out(pins_s)
  );

  // Any one wake source counts as wake
  assign key_s = pins_s[0];
  assign wake_s = pins_s[1] | pins_s[2] | pins_s[3];
  assign v5v_ok_s = pins_s[4];
  assign v5v_zero_s = pins_s[5];
  assign batt_s = pins_s[6];
  assign stby_s = pins_s[7];
  assign shut = powerdown_counter_overflow
    | secure_shutoff_timer_expired;

  // ============================================================
  // Microsecond tick divider
  localparam int DIV_W = $clog2(US_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(US_CYC - 1);
  logic [DIV_W-1:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb
  begin
    tick_nxt = (div_r == DIV_LAST);
    div_nxt = tick_nxt ? '0 : div_r + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ============================================================
  // Operation state machine
  op_state_e st_r, st_nxt; // R1
  logic relay_r, relay_nxt;
  logic [7:0] outs_r, outs_nxt;
  logic ae, ar, mr_r, wake_clear_select_sel_r;

  // Ramp timer only runs while the rails come up
  ovf_timer #(.W(TMR_W), .LIMIT(RAMP_US)) u_ramp_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(st_r == ST_RAMP),
    .tick(tick_r),
    .expired(ramp_ovf)
  );

  // Power-down timer runs only in general power-down
  ovf_timer #(.W(TMR_W), .LIMIT(PD_US)) u_pd_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(st_r == ST_PWRDN),
    .tick(tick_r),
    .expired(pd_ovf)
  );

  // Next state; watchdog shut-off outranks afterrun entry
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_SLEEP:
        if (key_s || wake_s) st_nxt = ST_RAMP; // R17
      ST_RAMP:
        if (!key_s && !wake_s) st_nxt = ST_SLEEP;
        else if (v5v_ok_s) st_nxt = ST_NORMAL; // R4
        else if (!key_s && ramp_ovf) st_nxt = ST_WAKE_CLEAR_SELECT; // R5 R13
      ST_NORMAL:
        if (!key_s && shut) st_nxt = ST_PWRDN;
        else if (!key_s && ae) st_nxt = ST_AFTERRUN; // R14
        else if (!key_s && !wake_s) st_nxt = ST_SLEEP;
      ST_AFTERRUN:
        if (shut) st_nxt = ST_PWRDN;
        else if (key_s && ar) st_nxt = ST_ARRESET; // R8
        else if (key_s) st_nxt = ST_NORMAL; // R15
        else if (!ae && !wake_s) st_nxt = ST_SLEEP;
      ST_ARRESET:
        st_nxt = ST_NORMAL; // R16
      ST_PWRDN:
        if (pd_ovf && v5v_zero_s) st_nxt = ST_WAKE_CLEAR_SELECT; // R10
      ST_WAKE_CLEAR_SELECT:
        if (key_s) st_nxt = ST_RAMP;
        else if (!wake_s) st_nxt = ST_SLEEP; // R12
      default:
        st_nxt = ST_SLEEP;
    endcase
  end

  // Relay follows the state being entered, so no stale cycle
  always_comb
  begin
    case (st_nxt)
      ST_RAMP: relay_nxt = batt_s;
      ST_NORMAL, ST_AFTERRUN, ST_ARRESET:
        relay_nxt = batt_s | mr_r; // R6 R7
      ST_PWRDN: relay_nxt = relay_r; // R9
      default: relay_nxt = 1'b0; // R2
    endcase
  end

  // Output word: {monrst_n,ext,int,wkc,sens,main}, stby, wkc_mode
  always_comb
  begin
    outs_nxt = '0;
    outs_nxt[0] = st_nxt inside {ST_RAMP, ST_NORMAL,
      ST_AFTERRUN, ST_ARRESET}; // R7 R9
    outs_nxt[1] = st_nxt inside {ST_NORMAL, ST_AFTERRUN,
      ST_ARRESET};
    outs_nxt[2] = (st_nxt == ST_WAKE_CLEAR_SELECT); // R11
    outs_nxt[3] = (st_nxt != ST_SLEEP); // R10
    outs_nxt[4] = st_nxt inside {ST_NORMAL, ST_AFTERRUN}; // R9
    outs_nxt[5] = st_nxt inside {ST_NORMAL, ST_AFTERRUN};
    outs_nxt[6] = stby_s; // R3
    outs_nxt[7] = wake_clear_select_sel_r; // R11
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= ST_SLEEP; // R17
      relay_r <= 1'b0;
      outs_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      relay_r <= relay_nxt;
      outs_r <= outs_nxt;
    end
  end

  assign main_relay_on = relay_r;
  assign main_5v_en = outs_r[0];
  assign sensor_rail_en = outs_r[1];
  assign wake_clear = outs_r[2];
  assign internal_supply_en = outs_r[3];
  assign ext_func_en = outs_r[4];
  assign monitor_reset_output_n = outs_r[5];
  assign standby_5v_en = outs_r[6];
  assign wake_circuit_en = outs_r[6]; // R3
  assign wake_clear_mode = outs_r[7];
  assign state_code = st_r; // R18

  // ============================================================
  // Register bus and interrupts
  logic dph_r, dph_nxt, wr_r, wr_nxt, ok_r, ok_nxt;
  logic [7:0] adr_r, adr_nxt;
  logic [1:0] cfg_r, cfg_nxt;
  logic mr_nxt, wake_clear_select_sel_nxt;
  logic [EV_W-1:0] sts_r, sts_nxt, msk_r, msk_nxt, ev;
  logic [31:0] rd_r, rd_nxt;
  logic wen;

  assign ae = cfg_r[CFG_AE_BIT];
  assign ar = cfg_r[CFG_AR_BIT];

  // Hardware events for the sticky status
  always_comb
  begin
    ev = '0;
    ev[EV_STATE] = (st_nxt != st_r);
    ev[EV_RAMPFAIL] = (st_r == ST_RAMP) && (st_nxt == ST_WAKE_CLEAR_SELECT);
    ev[EV_PWRDN] = (st_r != ST_PWRDN) && (st_nxt == ST_PWRDN);
    ev[EV_ARRESET] = (st_nxt == ST_ARRESET);
  end

  // Writes land in the wait cycle; set beats write-one-clear
  always_comb
  begin
    dph_nxt = 1'b0;
    adr_nxt = adr_r;
    wr_nxt = wr_r;
    ok_nxt = ok_r;
    if (!dph_r && hsel && htrans[1] && hready)
    begin
      dph_nxt = 1'b1;
      adr_nxt = haddr[7:0];
      wr_nxt = hwrite;
      ok_nxt = (haddr[31:8] == '0) && (hsize == HSIZE_WORD);
    end
    wen = dph_r && wr_r && ok_r;
    cfg_nxt = cfg_r;
    mr_nxt = mr_r;
    wake_clear_select_sel_nxt = wake_clear_select_sel_r;
    msk_nxt = msk_r;
    sts_nxt = sts_r;
    if (wen && adr_r == OFS_CFG) cfg_nxt = hwdata[1:0];
    if (wen && adr_r == OFS_STAT) mr_nxt = hwdata[STAT_MR_BIT];
    if (wen && adr_r == OFS_CMD)
      wake_clear_select_sel_nxt = hwdata[CMD_WAKE_CLEAR_SELECT_BIT];
    if (wen && adr_r == OFS_IRQ_MSK) msk_nxt = hwdata[EV_W-1:0];
    if (wen && adr_r == OFS_IRQ_STS)
      sts_nxt = sts_r & ~hwdata[EV_W-1:0];
    sts_nxt = sts_nxt | ev;
    rd_nxt = rd_r;
    if (dph_r)
    begin
      rd_nxt = '0;
      if (ok_r && !wr_r)
        case (adr_r)
          OFS_CFG: rd_nxt[1:0] = cfg_r;
          OFS_STAT: rd_nxt = {22'h00_0000, relay_r, mr_r, 1'b0,
            st_r};
          OFS_CMD: rd_nxt[CMD_WAKE_CLEAR_SELECT_BIT] = wake_clear_select_sel_r;
          OFS_IRQ_STS: rd_nxt[EV_W-1:0] = sts_r;
          OFS_IRQ_MSK: rd_nxt[EV_W-1:0] = msk_r;
          default: rd_nxt = '0;
        endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_r <= 1'b0;
      adr_r <= '0;
      wr_r <= 1'b0;
      ok_r <= 1'b0;
      cfg_r <= CFG_RST;
      mr_r <= MR_RST;
      wake_clear_select_sel_r <= WAKE_CLEAR_SELECT_RST;
      msk_r <= IRQ_MSK_RST;
      sts_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      dph_r <= dph_nxt;
      adr_r <= adr_nxt;
      wr_r <= wr_nxt;
      ok_r <= ok_nxt;
      cfg_r <= cfg_nxt;
      mr_r <= mr_nxt;
      wake_clear_select_sel_r <= wake_clear_select_sel_nxt;
      msk_r <= msk_nxt;
      sts_r <= sts_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Wait state lets the read follow a write issued just before
  assign hreadyout = !dph_r;
  assign hresp = 1'b0;
  assign hrdata = rd_r;
  assign irq = |(sts_r & msk_r);

  // ============================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_arr_enter;
    st_r == ST_AFTERRUN && key_s && ar && !shut;
  endsequence
  sequence s_arr_pass;
    st_r == ST_ARRESET ##1 st_r == ST_NORMAL;
  endsequence

  AST_ONE_HOT: assert property ($onehot(st_r)) // R1
    else $error("state code not one-hot");
  AST_SLEEP_OFF: assert property (st_r == ST_SLEEP |-> // R2
    !main_relay_on && !main_5v_en && !internal_supply_en)
    else $error("supply active in sleep");
  AST_SLEEP_STBY: assert property ( // R3
    st_r == ST_SLEEP && $past(stby_s) |-> standby_5v_en)
    else $error("standby rail off while supplied");
  AST_RAMP_DONE: assert property (st_r == ST_RAMP && // R4
    (key_s || wake_s) && v5v_ok_s |=> st_r == ST_NORMAL)
    else $error("ramp did not reach normal");
  AST_RAMP_FAIL: assert property (st_r == ST_RAMP && // R13
    !key_s && wake_s && !v5v_ok_s && ramp_ovf
    |=> st_r == ST_WAKE_CLEAR_SELECT ##0 wake_clear)
    else $error("ramp timeout not handled");
  AST_AFTERRUN_IN: assert property (st_r == ST_NORMAL && // R14
    !key_s && ae && !shut |=> st_r == ST_AFTERRUN ##0 main_5v_en)
    else $error("afterrun not entered");
  AST_NO_RESET: assert property (st_r == ST_AFTERRUN && // R15
    key_s && !ar && !shut |=> st_r == ST_NORMAL)
    else $error("afterrun re-entry wrong");
  AST_AR_PASS: assert property (s_arr_enter |=> s_arr_pass) // R16
    else $error("afterrun reset not one cycle");
  AST_PD_HOLD: assert property (st_r == ST_PWRDN && // R9
    $past(st_r) == ST_PWRDN |-> $stable(main_relay_on) &&
    !main_5v_en && !ext_func_en && internal_supply_en)
    else $error("power-down outputs wrong");
  AST_RELAY_NORMAL: assert property (st_r == ST_NORMAL && // R6
    $past(st_r) == ST_NORMAL |-> main_relay_on ==
    ($past(batt_s) | $past(mr_r)))
    else $error("relay not per battery or bit");
  AST_IRQ_STICKY: assert property (ev[EV_RAMPFAIL] // R5
    |=> sts_r[EV_RAMPFAIL])
    else $error("ramp failure event lost");

endmodule : ecu_opstate_ctrl

// *** logic/ovf_timer.sv ***
// Purpose: Tick counter that flags overflow while it is kept running
// Assumes: tick is a one-cycle enable from a divider
// Notes:   Dropping run clears count and flag at once
`timescale 1ns/1ps

// ==============================================================
// Overflow timer
module ovf_timer #(
  parameter int W = 16,
  parameter int LIMIT = 2000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic tick,
  // Result
  output logic expired
);

  if (LIMIT < 1 || LIMIT >= (1 << W))
  begin : g_chk
    $error("ovf_timer LIMIT does not fit W");
  end

  localparam logic [W-1:0] LAST = W'(LIMIT - 1);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;

  // Count ticks, latch the overflow until run falls
  always_comb
  begin
    cnt_nxt = '0;
    exp_nxt = 1'b0;
    if (run)
    begin
      exp_nxt = exp_r || (tick && cnt_r == LAST);
      cnt_nxt = (tick && !exp_r) ? cnt_r + 1'b1 : cnt_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;

endmodule : ovf_timer

// *** logic/pin_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter per bit
// Assumes: Inputs are asynchronous to hclk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps

// ==============================================================
// Synchroniser
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins in, filtered levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] s1_r, s2_r, s3_r, out_r, out_nxt;

  // Stage one feeds only stage two
  genvar i;
  for (i = 0; i < W; i++)
  begin : g_bit
    always_comb
    begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pin_out = out_r;

endmodule : pin_sync

// *** verification/ecu_operation_state_control_test.sv ***
// Purpose: Self-checking bench for the operation state controller
// Assumes: Timer spans shrunk to 4 us so the run stays short
// Notes:   Bus and state waits end only by the cycle ceiling
`timescale 1ns/1ps

// ==========================================================
// Bench top
module ecu_operation_state_control_test
  import ecu_opstate_pkg::*;
();
  // Bus and pins driven by the bench
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic key_pin = 1'h0;
  logic wake_pin_input = 1'h0;
  logic can_wake = 1'h0;
  logic battery_ok = 1'h0;
  logic standby_battery_pin = 1'h1;
  logic pd_ovf = 1'h0;
  logic fail = 1'h0;
  // Block outputs
  logic hreadyout, hresp, main_5v_ok, main_5v_zero, main_relay_on;
  logic main_5v_en, sensor_rail_en, standby_5v_en, wake_circuit_en;
  logic internal_supply_en, ext_func_en, monitor_reset_output_n;
  logic wake_clear, wake_clear_mode, irq;
  logic [6:0] state_code;
  logic [31:0] hrdata;
  logic [31:0] r;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  // 25 MHz clock
  always #20 hclk = ~hclk;

  // Block under test; slave hreadyout is the bus hready
  ecu_opstate_ctrl #(.RAMP_US(4), .PD_US(4)) i_ecu_opstate_ctrl (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .key_pin(key_pin),
    .wake_pin_input(wake_pin_input), .can_wake(can_wake),
    .eot_wake(1'h0), .main_5v_ok(main_5v_ok),
    .main_5v_zero(main_5v_zero), .battery_ok(battery_ok),
    .standby_battery_pin(standby_battery_pin),
    .powerdown_counter_overflow(pd_ovf),
    .secure_shutoff_timer_expired(1'h0),
    .main_relay_on(main_relay_on), .main_5v_en(main_5v_en),
    .sensor_rail_en(sensor_rail_en), .standby_5v_en(standby_5v_en),
    .wake_circuit_en(wake_circuit_en),
    .internal_supply_en(internal_supply_en),
    .ext_func_en(ext_func_en),
    .monitor_reset_output_n(monitor_reset_output_n),
    .wake_clear(wake_clear), .wake_clear_mode(wake_clear_mode),
    .state_code(state_code), .irq(irq));

  // External main rail
  ecu_supply_model #(.RISE(20)) i_ecu_supply_model (
    .hclk(hclk), .hresetn(hresetn), .main_5v_en(main_5v_en),
    .fail(fail), .main_5v_ok(main_5v_ok),
    .main_5v_zero(main_5v_zero));

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One AHB-Lite single word transfer; read data lands in r
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0000_0000);
  endtask : rd

  // Wait for a state code, then count it as a comparison
  task go(input op_state_e s);
    while (state_code !== s) @(posedge hclk);
    chk(state_code, s);
  endtask : go

  // Reset values, masking of unused bits, unmapped place
  task t_regs;
    rd(OFS_CFG);
    chk(r, 32'h0000_0000);
    wr(OFS_CFG, 32'hFFFF_FFFF);
    rd(OFS_CFG);
    chk(r, 32'h0000_0003);
    wr(OFS_CFG, 32'h0000_0000);
    rd(OFS_CMD);
    chk(r, 32'h0000_0000);
    rd(OFS_IRQ_MSK);
    chk(r, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk(r, 32'h0000_0000);
    rd(OFS_STAT);
    chk(r, 32'(ST_SLEEP));
    chk(hresp, 1'h0);
    chk(main_relay_on, 1'h0);
    chk(internal_supply_en, 1'h0);
    chk(standby_5v_en, 1'h1);
    chk(wake_circuit_en, 1'h1);
    $display("t_regs done");
  endtask : t_regs

  // Wake start, relay by status bit, interrupt mask and clear
  task t_wake;
    @(posedge hclk);
    wake_pin_input <= 1'h1;
    go(ST_RAMP);
    chk(main_5v_en, 1'h1);
    go(ST_NORMAL);
    chk(ext_func_en, 1'h1);
    chk(main_relay_on, 1'h0);
    wr(OFS_STAT, 32'h0000_0100);
    repeat (2) @(posedge hclk);
    chk(main_relay_on, 1'h1);
    rd(OFS_STAT);
    chk(r, 32'h0000_0304);
    rd(OFS_IRQ_STS);
    chk(r, 32'h0000_0001);
    chk(irq, 1'h0);
    wr(OFS_IRQ_MSK, 32'h0000_000F);
    chk(irq, 1'h1);
    wr(OFS_IRQ_STS, 32'h0000_0001);
    chk(irq, 1'h0);
    $display("t_wake done");
  endtask : t_wake

  // Afterrun with and without the reset step
  task t_after;
    wr(OFS_CFG, 32'h0000_0001);
    @(posedge hclk);
    key_pin <= 1'h1;
    repeat (8) @(posedge hclk);
    wake_pin_input <= 1'h0;
    key_pin <= 1'h0;
    go(ST_AFTERRUN);
    chk(sensor_rail_en, 1'h1);
    chk(monitor_reset_output_n, 1'h1);
    key_pin <= 1'h1;
    go(ST_NORMAL);
    wr(OFS_CFG, 32'h0000_0003);
    key_pin <= 1'h0;
    go(ST_AFTERRUN);
    key_pin <= 1'h1;
    go(ST_ARRESET);
    chk(monitor_reset_output_n, 1'h0);
    @(posedge hclk);
    chk(state_code, ST_NORMAL);
    rd(OFS_IRQ_STS);
    chk(r & 32'h0000_0008, 32'h0000_0008);
    $display("t_after done");
  endtask : t_after

  // Watchdog shut-off, power-down, wake clear, back to sleep
  task t_pwrdn;
    wr(OFS_CMD, 32'h0000_0001);
    wake_pin_input <= 1'h1;
    key_pin <= 1'h0;
    go(ST_AFTERRUN);
    pd_ovf <= 1'h1;
    go(ST_PWRDN);
    pd_ovf <= 1'h0;
    chk({main_5v_en, sensor_rail_en, ext_func_en}, 3'h0);
    chk(main_relay_on, 1'h1);
    chk(internal_supply_en, 1'h1);
    go(ST_WAKE_CLEAR_SELECT);
    chk(main_5v_zero, 1'h1);
    chk({wake_clear, wake_clear_mode}, 2'h3);
    rd(OFS_IRQ_STS);
    chk(r & 32'h0000_0004, 32'h0000_0004);
    wake_pin_input <= 1'h0;
    go(ST_SLEEP);
    chk({main_relay_on, internal_supply_en}, 2'h0);
    $display("t_pwrdn done");
  endtask : t_pwrdn

  // Shorted rail on a wake start, then reset with key high
  task t_fail;
    wr(OFS_CMD, 32'h0000_0000);
    wr(OFS_CFG, 32'h0000_0000);
    fail <= 1'h1;
    battery_ok <= 1'h1;
    can_wake <= 1'h1;
    go(ST_RAMP);
    chk(main_relay_on, 1'h1);
    go(ST_WAKE_CLEAR_SELECT);
    chk({wake_clear, wake_clear_mode}, 2'h2);
    rd(OFS_IRQ_STS);
    chk(r & 32'h0000_0002, 32'h0000_0002);
    can_wake <= 1'h0;
    go(ST_SLEEP);
    fail <= 1'h0;
    key_pin <= 1'h1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    chk(state_code, ST_SLEEP);
    hresetn <= 1'h1;
    go(ST_RAMP);
    go(ST_NORMAL);
    key_pin <= 1'h0;
    go(ST_SLEEP);
    $display("t_fail done");
  endtask : t_fail

  // Counts and verdict
  task summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Cycle ceiling cuts any hang short
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("[ERR] %0t cycle ceiling reached", $time);
      summarize();
    end
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs();
    t_wake();
    t_after();
    t_pwrdn();
    t_fail();
    summarize();
  end
endmodule : ecu_operation_state_control_test

// *** verification/ecu_supply_model.sv ***
// Purpose: Behavioural main 5 V rail with ramp-up and decay
// Assumes: One level step per hclk cycle
// Notes:   fail pins the rail low to mimic a shorted output
`timescale 1ns/1ps

// ==========================================================
// Supply model
module ecu_supply_model #(
  parameter int RISE = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control from the block and the bench
  input wire logic main_5v_en,
  input wire logic fail,
  // Comparator levels seen by the block
  output logic main_5v_ok,
  output logic main_5v_zero
);
  int lvl_r;

  // Rail climbs while enabled and decays when off or shorted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl_r <= 0;
    else if (main_5v_en && !fail && lvl_r < RISE)
      lvl_r <= lvl_r + 1;
    else if ((!main_5v_en || fail) && lvl_r > 0)
      lvl_r <= lvl_r - 1;
  end

  // Threshold comparators; a slow decay keeps power-down honest
  assign main_5v_ok = (lvl_r == RISE);
  assign main_5v_zero = (lvl_r == 0);
endmodule : ecu_supply_model
